//--- src/bst_regs.svh
`ifndef BST_REGS_SVH
`define BST_REGS_SVH
// ==========================================
// instruction register
`define BST_IR_WIDTH 3
`define BST_IR_EXTEST 3'h0
`define BST_IR_SAMPLE 3'h4
`define BST_IR_IDCODE 3'h6
`define BST_IR_BYPASS 3'h7
`define BST_IR_CAPTURE 3'h1
`define BST_IR_RESET 3'h6
// ==========================================
// identification register, field values arbitrary
`define BST_ID_WIDTH 32
`define BST_ID_PRODUCER 11'h001
`define BST_ID_PART 16'h0001
`define BST_ID_REVISION 4'h0
// ==========================================
// boundary chain layout
`define BST_CHAIN_LEN 98
`define BST_SEL_LINES 8
`define BST_SEL_DIR_CELL 16
`define BST_CHANNELS 8
`define BST_FLOAT_CELL_0 31
`define BST_FLOAT_CELL_1 23
`define BST_FLOAT_CELL_2 45
`define BST_FLOAT_CELL_3 37
`define BST_FLOAT_CELL_4 53
`define BST_FLOAT_CELL_5 61
`define BST_FLOAT_CELL_6 69
`define BST_FLOAT_CELL_7 77
// ==========================================
// reset value of the applied pattern: all drivers floated
`define BST_PATTERN_RESET 98'h3FFFFFFFFFFFFFFFFFFFFFFFF
`endif

//--- src/bst_pkg.sv
// ==========================================
// types of the boundary-scan port
package bst_pkg;
  // tap controller states, one-hot
  typedef enum logic [15:0] {
    BST_TLR    = 16'h0001,
    BST_RTI    = 16'h0002,
    BST_SEL_DR = 16'h0004,
    BST_CAP_DR = 16'h0008,
    BST_SH_DR  = 16'h0010,
    BST_EX1_DR = 16'h0020,
    BST_PAU_DR = 16'h0040,
    BST_EX2_DR = 16'h0080,
    BST_UPD_DR = 16'h0100,
    BST_SEL_IR = 16'h0200,
    BST_CAP_IR = 16'h0400,
    BST_SH_IR  = 16'h0800,
    BST_EX1_IR = 16'h1000,
    BST_PAU_IR = 16'h2000,
    BST_EX2_IR = 16'h4000,
    BST_UPD_IR = 16'h8000
  } bst_tap_state_t;
endpackage

//--- src/bst_boundary_scan_tap.sv
`include "bst_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module bst_boundary_scan_tap
  import bst_pkg::*;
(
  // system clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // test port, on the test clock
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  // functional core side
  input wire logic [7:0] i_core_sel_out,
  input wire logic i_core_sel_oe,
  input wire logic [7:0] i_core_rx_float,
  // pins
  input wire logic [7:0] i_sel_line_in,
  input wire logic [97:0] i_pin_sample,
  output logic [7:0] o_sel_line_out,
  output logic o_sel_line_oe,
  output logic [7:0] o_rx_float,
  output logic [97:0] o_bscan_pattern,
  output logic o_extest
);
  // float cell positions per channel
  localparam int float_cell [8] = '{`BST_FLOAT_CELL_0, `BST_FLOAT_CELL_1,
    `BST_FLOAT_CELL_2, `BST_FLOAT_CELL_3, `BST_FLOAT_CELL_4, `BST_FLOAT_CELL_5,
    `BST_FLOAT_CELL_6, `BST_FLOAT_CELL_7};
  localparam logic [31:0] id_value = {`BST_ID_REVISION, `BST_ID_PART,
    `BST_ID_PRODUCER, 1'b1};

  // ==========================================
  // test clock domain
  logic tck_rst_s1; // reset release, first stage
  logic tck_rst; // reset in test clock domain
  bst_tap_state_t state; // tap state
  bst_tap_state_t next_state; // next tap state
  logic [2:0] ir_shift; // instruction shift stage
  logic [2:0] ir; // current instruction
  logic bypass_bit; // one-bit bypass
  logic [31:0] id_shift; // identification shift
  logic [97:0] chain; // boundary shift chain
  logic [97:0] upd_reg; // updated pattern
  logic upd_tgl; // toggles on each update-dr with the boundary chain selected
  logic instr_extest; // extest selected, registered
  logic [97:0] cap_s1; // capture crossing, first stage
  logic [97:0] cap_s2; // capture crossing, second stage
  logic [97:0] cap_sys; // what capture-dr would see
  logic sel_bsr; // chain on the path
  logic sel_id; // id register on the path
  logic sel_byp; // bypass on the path
  logic dr_out; // data register serial out

  // reset: asserted at once, released on test clock
  always_ff @(posedge i_tck or posedge i_rst) begin
    if (i_rst) begin
      tck_rst_s1 <= 1'b1;
      tck_rst <= 1'b1;
    end else begin
      tck_rst_s1 <= 1'b0;
      tck_rst <= tck_rst_s1;
    end
  end

  // next tap state from mode select
  always_comb begin
    case (state)
      BST_TLR: next_state = i_tms ? BST_TLR : BST_RTI;
      BST_RTI: next_state = i_tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_DR: next_state = i_tms ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: next_state = i_tms ? BST_EX1_DR : BST_SH_DR;
      BST_SH_DR: next_state = i_tms ? BST_EX1_DR : BST_SH_DR;
      BST_EX1_DR: next_state = i_tms ? BST_UPD_DR : BST_PAU_DR;
      BST_PAU_DR: next_state = i_tms ? BST_EX2_DR : BST_PAU_DR;
      BST_EX2_DR: next_state = i_tms ? BST_UPD_DR : BST_SH_DR;
      BST_UPD_DR: next_state = i_tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_IR: next_state = i_tms ? BST_TLR : BST_CAP_IR;
      BST_CAP_IR: next_state = i_tms ? BST_EX1_IR : BST_SH_IR;
      BST_SH_IR: next_state = i_tms ? BST_EX1_IR : BST_SH_IR;
      BST_EX1_IR: next_state = i_tms ? BST_UPD_IR : BST_PAU_IR;
      BST_PAU_IR: next_state = i_tms ? BST_EX2_IR : BST_PAU_IR;
      BST_EX2_IR: next_state = i_tms ? BST_UPD_IR : BST_SH_IR;
      BST_UPD_IR: next_state = i_tms ? BST_SEL_DR : BST_RTI;
      default: next_state = BST_TLR;
    endcase
  end

  always_ff @(posedge i_tck or posedge tck_rst) begin
    if (tck_rst) begin
      state <= BST_TLR;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_tck or posedge tck_rst) begin
    if (tck_rst) begin
      ir_shift <= `BST_IR_CAPTURE;
    end else if (state == BST_CAP_IR) begin
      ir_shift <= `BST_IR_CAPTURE;
    end else if (state == BST_SH_IR) begin
      ir_shift <= {i_tdi, ir_shift[2:1]};
    end
  end

  // instruction update, idcode after test-logic-reset
  always_ff @(posedge i_tck or posedge tck_rst) begin
    if (tck_rst) begin
      ir <= `BST_IR_RESET;
    end else if (state == BST_TLR) begin
      ir <= `BST_IR_RESET;
    end else if (state == BST_UPD_IR) begin
      ir <= ir_shift;
    end
  end

  always_comb begin
    sel_bsr = (ir == `BST_IR_EXTEST) || (ir == `BST_IR_SAMPLE);
    sel_id = (ir == `BST_IR_IDCODE);
    sel_byp = !sel_bsr && !sel_id;
  end

  always_ff @(posedge i_tck or posedge tck_rst) begin
    if (tck_rst) begin
      bypass_bit <= 1'b0;
    end else if (sel_byp && state == BST_CAP_DR) begin
      bypass_bit <= 1'b0;
    end else if (sel_byp && state == BST_SH_DR) begin
      bypass_bit <= i_tdi;
    end
  end

  always_ff @(posedge i_tck or posedge tck_rst) begin
    if (tck_rst) begin
      id_shift <= 32'h00000000;
    end else if (sel_id && state == BST_CAP_DR) begin
      id_shift <= id_value;
    end else if (sel_id && state == BST_SH_DR) begin
      id_shift <= {i_tdi, id_shift[31:1]};
    end
  end

  // capture vector crossing from system domain, levels
  always_ff @(posedge i_tck or posedge tck_rst) begin
    if (tck_rst) begin
      cap_s1 <= '0;
      cap_s2 <= '0;
    end else begin
      cap_s1 <= cap_sys;
      cap_s2 <= cap_s1;
    end
  end

  always_ff @(posedge i_tck or posedge tck_rst) begin
    if (tck_rst) begin
      chain <= '0;
    end else if (sel_bsr && state == BST_CAP_DR) begin
      chain <= cap_s2;
    end else if (sel_bsr && state == BST_SH_DR) begin
      chain <= {i_tdi, chain[97:1]};
    end
  end

  // update register, toggle flags a new pattern
  always_ff @(posedge i_tck or posedge tck_rst) begin
    if (tck_rst) begin
      upd_reg <= `BST_PATTERN_RESET;
      upd_tgl <= 1'b0;
    end else if (sel_bsr && state == BST_UPD_DR) begin
      upd_reg <= chain;
      upd_tgl <= !upd_tgl;
    end
  end

  // extest level for the system domain, set with the instruction
  // so a test clock that stops after update-ir still reaches the pins
  always_ff @(posedge i_tck or posedge tck_rst) begin
    if (tck_rst) begin
      instr_extest <= 1'b0;
    end else if (state == BST_TLR) begin
      instr_extest <= 1'b0;
    end else if (state == BST_UPD_IR) begin
      instr_extest <= (ir_shift == `BST_IR_EXTEST);
    end
  end

  // serial out of the selected data register
  always_comb begin
    if (sel_bsr) begin
      dr_out = chain[0];
    end else if (sel_id) begin
      dr_out = id_shift[0];
    end else begin
      dr_out = bypass_bit;
    end
  end

  // data leaves on falling test clock edge
  always_ff @(negedge i_tck or posedge tck_rst) begin
    if (tck_rst) begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else begin
      o_tdo <= (state == BST_SH_IR) ? ir_shift[0] : dr_out;
      o_tdo_oe <= (state == BST_SH_IR) || (state == BST_SH_DR);
    end
  end

  // ==========================================
  // system clock domain
  logic [7:0] sel_in_s1; // select pin sync, first stage
  logic [7:0] sel_in_s2; // select pin sync, second stage
  logic [97:0] pin_s1; // pin sync, first stage
  logic [97:0] pin_s2; // pin sync, second stage
  logic ext_s1; // extest sync, first stage
  logic ext_s2; // extest sync, second stage
  logic tgl_s1; // update toggle, first stage
  logic tgl_s2; // update toggle, second stage
  logic tgl_s3; // update toggle, edge history
  logic [97:0] next_cap; // next capture vector

  // pin and control synchronisers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_in_s1 <= 8'h00;
      sel_in_s2 <= 8'h00;
      pin_s1 <= '0;
      pin_s2 <= '0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      sel_in_s1 <= i_sel_line_in;
      sel_in_s2 <= sel_in_s1;
      pin_s1 <= i_pin_sample;
      pin_s2 <= pin_s1;
      ext_s1 <= instr_extest;
      ext_s2 <= ext_s1;
      tgl_s1 <= upd_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  // select lines in cells 0 to 15: even cell drives, odd cell samples
  always_comb begin
    next_cap = pin_s2;
    for (int k = 0; k < `BST_SEL_LINES; k++) begin
      next_cap[2*k] = o_sel_line_out[k];
      next_cap[2*k+1] = sel_in_s2[k];
    end
    next_cap[`BST_SEL_DIR_CELL] = !o_sel_line_oe;
    for (int c = 0; c < `BST_CHANNELS; c++) begin
      next_cap[float_cell[c]] = o_rx_float[c];
    end
  end

  // capture vector register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cap_sys <= '0;
    end else begin
      cap_sys <= next_cap;
    end
  end

  // pattern taken on each update toggle
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bscan_pattern <= `BST_PATTERN_RESET;
      o_extest <= 1'b0;
    end else begin
      o_extest <= ext_s2;
      if (tgl_s2 != tgl_s3) begin
        o_bscan_pattern <= upd_reg;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sel_line_out <= 8'h00;
      o_sel_line_oe <= 1'b0;
    end else if (o_extest) begin
      for (int k = 0; k < `BST_SEL_LINES; k++) begin
        o_sel_line_out[k] <= o_bscan_pattern[2*k];
      end
      o_sel_line_oe <= !o_bscan_pattern[`BST_SEL_DIR_CELL];
    end else begin
      o_sel_line_out <= i_core_sel_out;
      o_sel_line_oe <= i_core_sel_oe;
    end
  end

  // receive outputs float on a one
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_float <= 8'hFF;
    end else begin
      for (int c = 0; c < `BST_CHANNELS; c++) begin
        o_rx_float[c] <= o_extest ? o_bscan_pattern[float_cell[c]] : i_core_rx_float[c];
      end
    end
  end

  // ==========================================
  // assertions
  a_tms_reset: assert property (@(posedge i_tck) disable iff (tck_rst)
    i_tms [*5] |=> state == BST_TLR) else $error("five tms highs did not reset tap");
  a_ir_capture: assert property (@(posedge i_tck) disable iff (tck_rst)
    state == BST_CAP_IR |=> ir_shift == 3'h1) else $error("ir capture value wrong");
  a_ir_lsb_first: assert property (@(posedge i_tck) disable iff (tck_rst)
    state == BST_SH_IR |=> ir_shift[2] == $past(i_tdi) && ir_shift[1:0] == $past(ir_shift[2:1]))
    else $error("ir shift order wrong");
  a_ir_update: assert property (@(posedge i_tck) disable iff (tck_rst)
    state == BST_UPD_IR |=> ir == $past(ir_shift)) else $error("ir not updated");
  a_bypass_delay: assert property (@(posedge i_tck) disable iff (tck_rst)
    state == BST_SH_DR && sel_byp |=> bypass_bit == $past(i_tdi))
    else $error("bypass delay not one clock");
  a_id_capture: assert property (@(posedge i_tck) disable iff (tck_rst)
    state == BST_CAP_DR && sel_id |=> id_shift == 32'h00001003 && id_shift[0])
    else $error("id capture value wrong");
  a_chain_guard: assert property (@(posedge i_tck) disable iff (tck_rst)
    !sel_bsr |=> $stable(chain)) else $error("chain changed outside boundary modes");
  a_bsr_update: assert property (@(posedge i_tck) disable iff (tck_rst)
    state == BST_UPD_DR && sel_bsr |=> upd_reg == $past(chain) && upd_tgl != $past(upd_tgl))
    else $error("boundary update lost");
  a_sel_direction: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_extest ##1 o_extest |-> o_sel_line_oe == !$past(o_bscan_pattern[`BST_SEL_DIR_CELL]))
    else $error("select direction not from cell 16");
endmodule
`default_nettype wire

//--- testbench/bst_jtag_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// external test controller model
module bst_jtag_ctrl_model (
  // test port lines
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo,
  input wire logic i_tdo_oe
);
  logic idle_tdi = 1'b0; // idle data, toggles so no stale level shows
  // test clock stands still low between frames
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // one test clock
  // lines set while low, tdo taken at the rising edge
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    idle_tdi = ~idle_tdi;
    #3;
    // released tdo reads as its pulled-up one
    tdo = i_tdo_oe ? i_tdo : 1'b1;
    o_tck = 1'b1;
    #3;
    o_tck = 1'b0;
  endtask
  // stay in run-test-idle for n clocks
  task automatic idle(input int n);
    logic d;
    for (int i = 0; i < n; i++) begin
      tick(1'b0, idle_tdi, d);
    end
  endtask
  // five ones reach reset, then idle
  task automatic go_idle();
    logic d;
    for (int i = 0; i < 5; i++) begin
      tick(1'b1, idle_tdi, d);
    end
    idle(1);
  endtask
  // instruction or data scan, lsb first
  // walks from idle through capture, shift, update back to idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic d;
    dout = '0;
    tick(1'b1, idle_tdi, d);
    if (ir) begin
      tick(1'b1, idle_tdi, d);
    end
    idle(2);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], d);
      dout[i] = d;
    end
    tick(1'b1, idle_tdi, d);
    idle(1);
  endtask
endmodule
`default_nettype wire

//--- testbench/test_boundary_scan_tap.sv
`timescale 1ns/1ps
`default_nettype none
`include "bst_regs.svh"
// ==========================================
// self-checking bench for the scan port
module test_boundary_scan_tap;
  import bst_pkg::*;
  typedef struct {string name; logic [127:0] val;} bst_note_t;
  // design inputs, all valued at time zero
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b0;
  logic i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe, o_sel_line_oe, o_extest;
  logic [7:0] i_core_sel_out = 8'h00;
  logic i_core_sel_oe = 1'b0;
  logic [7:0] i_core_rx_float = 8'hFF;
  logic [7:0] i_sel_line_in = 8'h00;
  logic [97:0] i_pin_sample = '0;
  logic [7:0] o_sel_line_out, o_rx_float;
  logic [97:0] o_bscan_pattern;
  // scoreboard state
  bst_note_t exp_q[$];
  logic [127:0] seen_q[$];
  int err_total = 0;
  int checks_done = 0;
  int seed = 70050;
  int fl[8] = '{31, 23, 45, 37, 53, 61, 69, 77}; // float cells per channel
  logic [2:0] codes[5] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h5}; // bypass codes
  localparam logic [127:0] ID = {96'h0, `BST_ID_REVISION, `BST_ID_PART, `BST_ID_PRODUCER, 1'b1};

  always #12.5 i_sys_clk = ~i_sys_clk;

  bst_boundary_scan_tap uut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_tck(i_tck), .i_tms(i_tms),
    .i_tdi(i_tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
    .i_core_sel_out(i_core_sel_out), .i_core_sel_oe(i_core_sel_oe),
    .i_core_rx_float(i_core_rx_float), .i_sel_line_in(i_sel_line_in),
    .i_pin_sample(i_pin_sample), .o_sel_line_out(o_sel_line_out),
    .o_sel_line_oe(o_sel_line_oe), .o_rx_float(o_rx_float),
    .o_bscan_pattern(o_bscan_pattern), .o_extest(o_extest)
  );
  bst_jtag_ctrl_model model (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi), .i_tdo(o_tdo),
    .i_tdo_oe(o_tdo_oe));

  // ==========================================
  // helpers
  function automatic logic [127:0] rnd();
    return {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction
  // pin-side outputs packed for one compare
  function automatic logic [127:0] pins();
    return {12'h000, o_bscan_pattern, o_sel_line_out, o_sel_line_oe, o_rx_float, o_extest};
  endfunction
  task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic note(input string name, input logic [127:0] val);
    exp_q.push_back('{name, val});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watcher: oldest note against each result seen
  initial begin
    bst_note_t n;
    logic [127:0] s;
    forever begin
      wait (seen_q.size() > 0);
      s = seen_q.pop_front();
      n = exp_q.pop_front();
      check(n.name, s, n.val);
    end
  end

  // watchdog, far beyond the expected run of some 5 us
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end

  // ==========================================
  // main sequence
  initial begin
    logic [127:0] o, p;
    logic [7:0] so, rf;
    @(negedge i_sys_clk);
    i_rst = 1'b1;
    repeat (8) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst = 1'b0;
    model.go_idle();
    // identification straight after reset
    note("reset idcode", ID);
    model.scan(1'b0, 32, rnd(), o);
    seen_q.push_back(o);
    $display("test reset idcode done");
    // every bypass code: one-cycle path with a zero captured first
    foreach (codes[i]) begin
      note("ir capture", 128'h1);
      model.scan(1'b1, 3, {125'h0, codes[i]}, o);
      seen_q.push_back(o);
      p = rnd();
      note("bypass path", {112'h0, p[14:0], 1'b0});
      model.scan(1'b0, 16, p, o);
      seen_q.push_back(o);
    end
    $display("test bypass done");
    // identification selected by its own code
    note("ir capture", 128'h1);
    model.scan(1'b1, 3, 128'h6, o);
    seen_q.push_back(o);
    note("idcode", ID);
    model.scan(1'b0, 32, rnd(), o);
    seen_q.push_back(o);
    $display("test idcode done");
    // sample and preload with functional path kept
    @(negedge i_sys_clk);
    p = rnd();
    i_pin_sample = p[97:0];
    i_sel_line_in = p[105:98];
    i_core_sel_out = p[113:106];
    i_core_rx_float = p[121:114];
    i_core_sel_oe = 1'b1;
    repeat (6) @(posedge i_sys_clk);
    note("ir capture", 128'h1);
    model.scan(1'b1, 3, 128'h4, o);
    seen_q.push_back(o);
    model.idle(4);
    o = {30'h0, i_pin_sample};
    for (int k = 0; k < 8; k++) begin
      o[2 * k] = i_core_sel_out[k];
      o[2 * k + 1] = i_sel_line_in[k];
      o[fl[k]] = i_core_rx_float[k];
    end
    o[16] = ~i_core_sel_oe;
    note("sample capture", o);
    p = rnd();
    model.scan(1'b0, 98, p, o);
    seen_q.push_back(o);
    repeat (8) @(negedge i_sys_clk);
    note("preload pins", {12'h000, p[97:0], i_core_sel_out, 1'b1, i_core_rx_float, 1'b0});
    seen_q.push_back(pins());
    $display("test sample done");
    // external test drives pins, both directions of cell 16
    note("ir capture", 128'h1);
    model.scan(1'b1, 3, 128'h0, o);
    seen_q.push_back(o);
    for (int t = 0; t < 2; t++) begin
      p = rnd();
      p[16] = t[0];
      model.scan(1'b0, 98, p, o);
      for (int k = 0; k < 8; k++) begin
        so[k] = p[2 * k];
        rf[k] = p[fl[k]];
      end
      repeat (8) @(negedge i_sys_clk);
      note("extest pins", {12'h000, p[97:0], so, ~p[16], rf, 1'b1});
      seen_q.push_back(pins());
    end
    $display("test extest done");
    // five ones restore identification and release the pins
    model.go_idle();
    repeat (8) @(negedge i_sys_clk);
    note("extest off", 128'h0);
    seen_q.push_back({126'h0, o_tdo_oe, o_extest});
    note("idcode after reset", ID);
    model.scan(1'b0, 32, rnd(), o);
    seen_q.push_back(o);
    $display("test tap reset done");
    wait (seen_q.size() == 0);
    #1;
    wrap_up();
  end
endmodule
`default_nettype wire
